// ==== uhs_pkg.sv ====
`default_nettype none
package uhs_pkg;
   // ==========================================================
   // register port
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;

   // ==========================================================
   // register offsets
   localparam logic [2:0] OFS_GEN_CTL = 3'h0;
   localparam logic [2:0] OFS_CTL_A   = 3'h1;
   localparam logic [2:0] OFS_CTL_B   = 3'h2;
   localparam logic [2:0] OFS_DDR_A   = 3'h3;
   localparam logic [2:0] OFS_DDR_B   = 3'h4;
   localparam logic [2:0] OFS_DATA_A  = 3'h5;
   localparam logic [2:0] OFS_DATA_B  = 3'h6;
   localparam logic [2:0] OFS_STATUS  = 3'h7;

   // ==========================================================
   // reset values
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [2:0] CNT_RST  = 3'h0;

   // ==========================================================
   // field positions
   localparam int unsigned CTL_SUB_LO  = 6;
   localparam int unsigned CTL_AUX_LO  = 3;
   localparam int unsigned CTL_AUX_IE  = 2;
   localparam int unsigned CTL_SVC_EN  = 1;
   localparam int unsigned GEN_EN_LO   = 4;
   localparam int unsigned GEN_DMA_SEL = 7;

   // ==========================================================
   // field encodings
   localparam logic [1:0] SUB_DBL_IN  = 2'h0;
   localparam logic [1:0] SUB_DBL_OUT = 2'h1;
   localparam logic [2:0] AUX_NEG     = 3'h4;
   localparam logic [2:0] AUX_ASR     = 3'h5;
   localparam logic [2:0] AUX_ILK     = 3'h6;
   localparam logic [2:0] AUX_PLS     = 3'h7;

   // ==========================================================
   // timing
   localparam logic [2:0] PULSE_CYC = 3'h4;

   typedef enum logic [1:0] {UHS_EMPTY, UHS_ONE, UHS_FULL} uhs_fill_e;
endpackage : uhs_pkg
`default_nettype wire

// ==== uhs_in_path.sv ====
`default_nettype none
module uhs_in_path
   import uhs_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // control
   input  wire logic       path_en_i,
   input  wire logic [2:0] aux_mode_i,
   input  wire logic       aux_sense_i,
   // peripheral side
   input  wire logic       strobe_edge_i,
   input  wire logic [7:0] data_i,
   // host side
   input  wire logic       pop_i,
   output logic      [7:0] final_o,
   output logic            present_o,
   output logic            aux_out_o
);
   // ==========================================================
   // latch pair
   uhs_fill_e  fill_reg;
   uhs_fill_e  fill_next;
   logic [7:0] init_reg;
   logic [7:0] final_reg;
   logic       ready_reg;
   logic       aux_reg;
   logic [2:0] pcnt_reg;

   wire logic hs_out = aux_mode_i[2] & aux_mode_i[1];
   wire logic ilk    = hs_out & ~aux_mode_i[0];
   wire logic accept = path_en_i & strobe_edge_i & (fill_reg != UHS_FULL)
                       & ~(ilk & ~ready_reg);
   wire logic pop_ok = path_en_i & pop_i & (fill_reg != UHS_EMPTY);

   always_comb begin
      case (fill_reg)
         UHS_EMPTY: fill_next = accept ? UHS_ONE : UHS_EMPTY;
         UHS_ONE:   fill_next = (accept == pop_ok) ? UHS_ONE
                                : (accept ? UHS_FULL : UHS_EMPTY);
         UHS_FULL:  fill_next = pop_ok ? UHS_ONE : UHS_FULL;
         default:   fill_next = UHS_EMPTY;
      endcase
      if (!path_en_i) begin
         fill_next = UHS_EMPTY;
      end
   end

   // ==========================================================
   // ready output
   wire logic cond = path_en_i & hs_out & (fill_next != UHS_FULL)
                     & ~strobe_edge_i;
   wire logic [2:0] pcnt_next = !cond ? CNT_RST
                    : (pcnt_reg == PULSE_CYC) ? pcnt_reg : pcnt_reg + 3'h1;
   wire logic ready_next = cond & (ilk | (pcnt_reg < PULSE_CYC));
   wire logic aux_asrt   = (aux_mode_i == AUX_ASR) | (hs_out & ready_next);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         fill_reg  <= UHS_EMPTY;
         init_reg  <= REG_RST;
         final_reg <= REG_RST;
         ready_reg <= 1'b0;
         aux_reg   <= 1'b0;
         pcnt_reg  <= CNT_RST;
      end else begin
         fill_reg  <= fill_next;
         ready_reg <= ready_next;
         aux_reg   <= ~(aux_sense_i ^ aux_asrt);
         pcnt_reg  <= pcnt_next;
         if (accept && (fill_reg == UHS_EMPTY || pop_ok)) begin
            final_reg <= data_i;
         end else if (accept) begin
            init_reg <= data_i;
         end else if (pop_ok && fill_reg == UHS_FULL) begin
            final_reg <= init_reg;
         end
      end
   end

   assign final_o   = final_reg;
   assign present_o = (fill_reg != UHS_EMPTY);
   assign aux_out_o = aux_reg;
endmodule : uhs_in_path
`default_nettype wire

// ==== uhs_port_top.sv ====
// Operation
// - two ports, independent, three submodes each
// - each port's strobe, latch pair and aux flag gated by its enable
// - dma serves one port, never bit I/O
// - direction bit enables pin output buffer
// - data read/write source set by submode, direction
// - strobe edge captures data into latch pair
// - strobe flag set while unread data held
// - aux control field selects aux pin function
// - aux input edge sets flag; write-one clears
// - interlocked ready drops on strobe, returns later
// - strobes ignored while interlocked ready negated
// - pulsed ready lasts four cycles at most
// - disabled port holds handshake output negated
// - output pins double latched in double-out submode; data writes touch no flags
// - each data read removes one entry
// - control bit 2 gates aux interrupt
// - control bit 1 gates strobe service, dma
// - sense bits set handshake pin polarity
// - disabled port holds latch pair empty
`default_nettype none
module uhs_port_top
   import uhs_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   // port a pins
   input  wire logic [7:0]        port_a_data_i,
   output logic      [7:0]        port_a_data_o,
   output logic      [7:0]        port_a_data_oe_o,
   input  wire logic              port_a_strobe_in_i,
   input  wire logic              port_a_aux_handshake_i,
   output logic                   port_a_aux_handshake_o,
   output logic                   port_a_aux_handshake_oe_o,
   // port b pins
   input  wire logic [7:0]        port_b_data_i,
   output logic      [7:0]        port_b_data_o,
   output logic      [7:0]        port_b_data_oe_o,
   input  wire logic              port_b_strobe_in_i,
   input  wire logic              port_b_aux_handshake_i,
   output logic                   port_b_aux_handshake_o,
   output logic                   port_b_aux_handshake_oe_o,
   // requests
   output logic                   dma_request_out_o,
   output logic                   service_request_o
);
   // ==========================================================
   // shared registers
   logic [7:0] gen_reg;
   logic [7:0] rdata_reg;
   logic       dma_reg;
   logic       svc_reg;

   wire logic [7:0] pin_in [2];
   wire logic       stb_pin [2];
   wire logic       aux_pin [2];
   wire logic [7:0] ctl_w [2];
   wire logic [7:0] ddr_w [2];
   wire logic [7:0] fol_w [2];
   wire logic [7:0] rd_w [2];
   wire logic       present_w [2];
   wire logic       aux_flag_w [2];
   wire logic       aux_out_w [2];
   wire logic       aux_oe_w [2];
   wire logic       edge_w [2];
   wire logic       aux_edge_w [2];
   wire logic       hs_en_w [2];
   wire logic       pop_w [2];
   wire logic       wr_data_w [2];

   assign pin_in[0]  = port_a_data_i;
   assign pin_in[1]  = port_b_data_i;
   assign stb_pin[0] = port_a_strobe_in_i;
   assign stb_pin[1] = port_b_strobe_in_i;
   assign aux_pin[0] = port_a_aux_handshake_i;
   assign aux_pin[1] = port_b_aux_handshake_i;

   // ==========================================================
   // write decode
   wire logic wr_gen  = reg_wr_i & (reg_addr_i == OFS_GEN_CTL);
   wire logic wr_stat = reg_wr_i & (reg_addr_i == OFS_STATUS);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         gen_reg <= REG_RST;
      end else if (wr_gen) begin
         gen_reg <= reg_wdata_i;
      end
   end

   // ==========================================================
   // per-port logic
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         localparam logic [2:0] OFS_CTL  = (p == 0) ? OFS_CTL_A : OFS_CTL_B;
         localparam logic [2:0] OFS_DDR  = (p == 0) ? OFS_DDR_A : OFS_DDR_B;
         localparam logic [2:0] OFS_DATA = (p == 0) ? OFS_DATA_A : OFS_DATA_B;

         logic [7:0] ctl_reg;
         logic [7:0] ddr_reg;
         logic [7:0] fol_reg;
         logic [7:0] iol_reg;
         logic       stb_lvl_reg;
         logic       aux_lvl_reg;
         logic       aux_flag_reg;
         logic       aux_oe_reg;
         logic [7:0] final_input_latch;

         wire logic [1:0] sub   = ctl_reg[CTL_SUB_LO +: 2];
         wire logic [2:0] auxm  = ctl_reg[CTL_AUX_LO +: 3];
         wire logic       hs_en = gen_reg[GEN_EN_LO + p];
         wire logic       s_stb = gen_reg[2 * p];
         wire logic       s_aux = gen_reg[2 * p + 1];

         // asserted level follows the sense bit
         wire logic stb_lvl  = ~(stb_pin[p] ^ s_stb);
         wire logic aux_lvl  = ~(aux_pin[p] ^ s_aux);
         wire logic stb_edge = stb_lvl & ~stb_lvl_reg;
         wire logic aux_edge = aux_lvl & ~aux_lvl_reg;

         wire logic wr_ctl  = reg_wr_i & (reg_addr_i == OFS_CTL);
         wire logic wr_ddr  = reg_wr_i & (reg_addr_i == OFS_DDR);
         wire logic wr_data = reg_wr_i & (reg_addr_i == OFS_DATA);
         wire logic pop     = reg_rd_i & (reg_addr_i == OFS_DATA);
         wire logic path_en = hs_en & (sub == SUB_DBL_IN);

         // aux status flag: set wins over clear
         wire logic flag_set  = aux_edge & ~auxm[2] & hs_en;
         wire logic flag_clr  = wr_stat & reg_wdata_i[2 * p + 1];
         wire logic flag_hold = ~hs_en | auxm[2];
         wire logic flag_next = flag_set | (aux_flag_reg & ~flag_clr & ~flag_hold);

         // read source per bit
         wire logic [7:0] src = (sub == SUB_DBL_IN) ? final_input_latch : pin_in[p];
         wire logic [7:0] rd  = (ddr_reg & fol_reg) | (~ddr_reg & src);

         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               ctl_reg      <= REG_RST;
               ddr_reg      <= REG_RST;
               fol_reg      <= REG_RST;
               iol_reg      <= REG_RST;
               stb_lvl_reg  <= 1'b0;
               aux_lvl_reg  <= 1'b0;
               aux_flag_reg <= 1'b0;
               aux_oe_reg   <= 1'b0;
            end else begin
               stb_lvl_reg  <= stb_lvl;
               aux_lvl_reg  <= aux_lvl;
               aux_flag_reg <= flag_next;
               aux_oe_reg   <= auxm[2];
               if (wr_ctl) begin
                  ctl_reg <= reg_wdata_i;
               end
               if (wr_ddr) begin
                  ddr_reg <= reg_wdata_i;
               end
               if (wr_data && sub == SUB_DBL_OUT) begin
                  iol_reg <= reg_wdata_i;
               end else if (wr_data) begin
                  fol_reg <= reg_wdata_i;
               end
               if (!wr_data && stb_edge && hs_en && sub == SUB_DBL_OUT) begin
                  fol_reg <= iol_reg;
               end
            end
         end

         uhs_in_path u_in (
            .clk_sys_i     (clk_sys_i),
            .rst_i         (rst_i),
            .path_en_i     (path_en),
            .aux_mode_i    (auxm),
            .aux_sense_i   (s_aux),
            .strobe_edge_i (stb_edge),
            .data_i        (pin_in[p]),
            .pop_i         (pop),
            .final_o       (final_input_latch),
            .present_o     (present_w[p]),
            .aux_out_o     (aux_out_w[p])
         );

         assign ctl_w[p]      = ctl_reg;
         assign ddr_w[p]      = ddr_reg;
         assign fol_w[p]      = fol_reg;
         assign rd_w[p]       = rd;
         assign aux_flag_w[p] = aux_flag_reg;
         assign aux_oe_w[p]   = aux_oe_reg;
         assign edge_w[p]     = stb_edge;
         assign aux_edge_w[p] = aux_edge;
         assign hs_en_w[p]    = hs_en;
         assign pop_w[p]      = pop;
         assign wr_data_w[p]  = wr_data;
      end
   endgenerate

   // ==========================================================
   // status and read mux
   wire logic [7:0] stat = {4'h0, aux_flag_w[1], present_w[1],
                            aux_flag_w[0], present_w[0]};
   wire logic [7:0] rd_mux =
        (reg_addr_i == OFS_GEN_CTL) ? gen_reg
      : (reg_addr_i == OFS_CTL_A)   ? ctl_w[0]
      : (reg_addr_i == OFS_CTL_B)   ? ctl_w[1]
      : (reg_addr_i == OFS_DDR_A)   ? ddr_w[0]
      : (reg_addr_i == OFS_DDR_B)   ? ddr_w[1]
      : (reg_addr_i == OFS_DATA_A)  ? rd_w[0]
      : (reg_addr_i == OFS_DATA_B)  ? rd_w[1]
      : stat;

   // ==========================================================
   // dma and service requests
   wire logic       dsel  = gen_reg[GEN_DMA_SEL];
   wire logic [7:0] dctl  = dsel ? ctl_w[1] : ctl_w[0];
   wire logic       dma_next = (dsel ? present_w[1] : present_w[0])
                      & (dsel ? hs_en_w[1] : hs_en_w[0])
                      & dctl[CTL_SVC_EN] & ~dctl[CTL_SUB_LO + 1];
   wire logic aux_irq = (aux_flag_w[0] & ctl_w[0][CTL_AUX_IE])
                      | (aux_flag_w[1] & ctl_w[1][CTL_AUX_IE]);
   wire logic stb_irq = (present_w[0] & ctl_w[0][CTL_SVC_EN] & dsel)
                      | (present_w[1] & ctl_w[1][CTL_SVC_EN] & ~dsel);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= REG_RST;
         dma_reg   <= 1'b0;
         svc_reg   <= 1'b0;
      end else begin
         rdata_reg <= reg_rd_i ? rd_mux : REG_RST;
         dma_reg   <= dma_next;
         svc_reg   <= aux_irq | stb_irq;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata_o               = rdata_reg;
   assign port_a_data_o             = fol_w[0];
   assign port_a_data_oe_o          = ddr_w[0];
   assign port_a_aux_handshake_o    = aux_out_w[0];
   assign port_a_aux_handshake_oe_o = aux_oe_w[0];
   assign port_b_data_o             = fol_w[1];
   assign port_b_data_oe_o          = ddr_w[1];
   assign port_b_aux_handshake_o    = aux_out_w[1];
   assign port_b_aux_handshake_oe_o = aux_oe_w[1];
   assign dma_request_out_o         = dma_reg;
   assign service_request_o         = svc_reg;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   wire logic [2:0] auxm_a = ctl_w[0][CTL_AUX_LO +: 3];
   wire logic       asrt_a = ~(port_a_aux_handshake_o ^ gen_reg[1]);
   logic [2:0]      run_a;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         run_a <= CNT_RST;
      end else if (!asrt_a) begin
         run_a <= CNT_RST;
      end else if (run_a != 3'h7) begin
         run_a <= run_a + 3'h1;
      end
   end

   a_aux_neg_level: assert property (
      (auxm_a == AUX_NEG)[*2] ##0 $stable(gen_reg[1])
      |-> port_a_aux_handshake_o != gen_reg[1])
      else $error("aux output not negated");

   a_aux_asr_level: assert property (
      (auxm_a == AUX_ASR)[*2] ##0 $stable(gen_reg[1]) |-> asrt_a)
      else $error("aux output not asserted");

   a_ready_drops: assert property (
      edge_w[0] && auxm_a[2:1] == 2'h3 |=> !asrt_a || !$stable(gen_reg[1]))
      else $error("ready not negated after strobe");

   a_ilk_refuse: assert property (
      edge_w[0] && hs_en_w[0] && ctl_w[0][CTL_SUB_LO +: 2] == SUB_DBL_IN
      && auxm_a == AUX_ILK && !asrt_a && $stable(gen_reg[1]) && !pop_w[0]
      |=> $stable(present_w[0]))
      else $error("strobe taken while not ready");

   a_aux_flag_set: assert property (
      aux_edge_w[0] && !auxm_a[2] && hs_en_w[0] |=> aux_flag_w[0])
      else $error("aux flag missed edge");

   a_aux_flag_off: assert property (
      !hs_en_w[0] || auxm_a[2] |=> !aux_flag_w[0])
      else $error("aux flag not held clear");

   a_empty_disabled: assert property (
      !hs_en_w[0] |=> !present_w[0])
      else $error("latch pair not empty");

   a_hs_off_neg: assert property (
      (!hs_en_w[0] && auxm_a[2:1] == 2'h3 && $stable(gen_reg[1]))[*2]
      |-> port_a_aux_handshake_o != gen_reg[1])
      else $error("handshake not held negated");

   a_pulse_length: assert property (
      (auxm_a == AUX_PLS && $stable(gen_reg[1]))[*8] |-> run_a <= PULSE_CYC)
      else $error("pulse too long");

   a_dma_bit_io: assert property (
      !gen_reg[GEN_DMA_SEL] && ctl_w[0][CTL_SUB_LO + 1] |=> !dma_request_out_o)
      else $error("dma request in bit io");

   a_write_no_flag: assert property (
      wr_data_w[0] && !edge_w[0] && $stable(hs_en_w[0]) |=> $stable(present_w[0]))
      else $error("data write changed flag");

   a_strobe_fills: assert property (
      edge_w[0] && hs_en_w[0] && ctl_w[0][CTL_SUB_LO +: 2] == SUB_DBL_IN
      && auxm_a != AUX_ILK |=> present_w[0])
      else $error("strobe not captured");

   a_svc_gated: assert property (
      !ctl_w[0][CTL_SVC_EN] && !ctl_w[1][CTL_SVC_EN]
      && !ctl_w[0][CTL_AUX_IE] && !ctl_w[1][CTL_AUX_IE] |=> !service_request_o)
      else $error("service request not gated");

   c_full_pulse:  cover property (run_a == PULSE_CYC ##1 !asrt_a);
   c_dma_request: cover property (dma_request_out_o);
   c_aux_flag:    cover property ($rose(aux_flag_w[0]));
   c_data_pop:    cover property (pop_w[0] && present_w[0]);
   c_ilk_refuse:  cover property (edge_w[0] && auxm_a == AUX_ILK && !asrt_a);
endmodule : uhs_port_top
`default_nettype wire

// ==== uhs_periph_model.sv ====
`default_nettype none
module uhs_periph_model (
   // clock
   input  wire logic       clk_sys_i,
   // device side
   input  wire logic       ready_pin_i,
   output logic            strobe_o,
   output logic      [7:0] data_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // idle: strobe negated high, data shows the inverse of the last byte
   initial begin
      strobe_o = 1'b1;
      data_o   = 8'h00;
   end

   // ==========================================================
   // one transfer; with obey set, strobe only once ready is low
   task automatic send(input logic [7:0] b, input logic obey, output logic ok);
      int n;
      n  = 0;
      ok = 1'b1;
      while (obey && ready_pin_i !== 1'b0 && n < 50) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (obey && ready_pin_i !== 1'b0) begin
         ok = 1'b0;
      end
      if (ok) begin
         @(posedge clk_sys_i);
         data_o   <= b;
         strobe_o <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         strobe_o <= 1'b1;
         data_o   <= ~b;
         repeat (2) @(posedge clk_sys_i);
      end
   endtask : send
endmodule : uhs_periph_model
`default_nettype wire

// ==== uhs_port_top_tb.sv ====
`default_nettype none
module uhs_port_top_tb
   import uhs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic [2:0] addr;
      logic [7:0] wdata;
   } uhs_row_s;

   logic       clk_sys_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic [2:0] reg_addr  = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic       aux_in    = 1'b1;
   wire  [7:0] rdata;
   wire  [7:0] a_data_in;
   wire  [7:0] a_data_out;
   wire  [7:0] a_oe;
   wire  [7:0] b_oe;
   wire  [7:0] b_data_out;
   wire        a_strobe;
   wire        a_aux;
   wire        a_aux_oe;
   wire        b_aux;
   wire        b_aux_oe;
   wire        dma_req;
   wire        svc_req;
   int         bad_count = 0;
   int         tests_run = 0;
   logic [7:0] v;
   logic       ok;
   int         lows;
   uhs_row_s   rows [4] = '{'{OFS_CTL_A, 8'h2A}, '{OFS_CTL_B, 8'h95},
                            '{OFS_DDR_A, 8'hF0}, '{OFS_DDR_B, 8'h0F}};
   logic [2:0] codes [3] = '{AUX_NEG, AUX_ASR, AUX_ILK};
   logic       exp_aux [3] = '{1'b1, 1'b0, 1'b0};

   always #2.5 clk_sys_i = ~clk_sys_i;

   uhs_port_top DUT (
      .clk_sys_i                 (clk_sys_i),
      .rst_i                     (rst_i),
      .reg_addr_i                (reg_addr),
      .reg_wdata_i               (reg_wdata),
      .reg_wr_i                  (reg_wr),
      .reg_rd_i                  (reg_rd),
      .reg_rdata_o               (rdata),
      .port_a_data_i             (a_data_in),
      .port_a_data_o             (a_data_out),
      .port_a_data_oe_o          (a_oe),
      .port_a_strobe_in_i        (a_strobe),
      .port_a_aux_handshake_i    (aux_in),
      .port_a_aux_handshake_o    (a_aux),
      .port_a_aux_handshake_oe_o (a_aux_oe),
      .port_b_data_i             (8'h00),
      .port_b_data_o             (b_data_out),
      .port_b_data_oe_o          (b_oe),
      .port_b_strobe_in_i        (1'b1),
      .port_b_aux_handshake_i    (1'b1),
      .port_b_aux_handshake_o    (b_aux),
      .port_b_aux_handshake_oe_o (b_aux_oe),
      .dma_request_out_o         (dma_req),
      .service_request_o         (svc_req)
   );

   uhs_periph_model periph (
      .clk_sys_i   (clk_sys_i),
      .ready_pin_i (a_aux),
      .strobe_o    (a_strobe),
      .data_o      (a_data_in)
   );

   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys_i);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys_i);
      reg_rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : settle

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle(1);
      chk("dma_reset", {7'h00, dma_req}, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk("row_readback", v, rows[i].wdata);
      end
      chk("oe_a", a_oe, 8'hF0);
      chk("oe_b", b_oe, 8'h0F);
      wr(OFS_DATA_A, 8'h3C);
      wr(OFS_DATA_B, 8'hA5);
      settle(2);
      chk("out_latch_a", a_data_out, 8'h3C);
      chk("out_latch_b", b_data_out, 8'hA5);
      chk("aux_b", {6'h00, b_aux, b_aux_oe}, 8'h02);
      rd(OFS_DATA_B, v);
      chk("pin_read_b", v, 8'h05);
      rd(OFS_STATUS, v);
      chk("status_after_wr", v, 8'h00);
      // fixed and ready settings of the aux pin
      wr(OFS_GEN_CTL, 8'h10);
      foreach (codes[i]) begin
         wr(OFS_CTL_A, {2'b00, codes[i], 3'b000});
         settle(3);
         chk("aux_out", {7'h00, a_aux}, {7'h00, exp_aux[i]});
         chk("aux_oe", {7'h00, a_aux_oe}, 8'h01);
      end
      // interlocked input transfers
      wr(OFS_CTL_A, 8'h32);
      wr(OFS_GEN_CTL, 8'h00);
      settle(3);
      chk("aux_disabled", {7'h00, a_aux}, 8'h01);
      wr(OFS_GEN_CTL, 8'h10);
      periph.send(8'h5A, 1'b1, ok);
      chk("ready_first", {7'h00, ok}, 8'h01);
      rd(OFS_STATUS, v);
      chk("present", v, 8'h01);
      chk("dma_a", {7'h00, dma_req}, 8'h01);
      periph.send(8'hC3, 1'b1, ok);
      chk("ready_second", {7'h00, ok}, 8'h01);
      settle(1);
      chk("aux_full", {7'h00, a_aux}, 8'h01);
      periph.send(8'h99, 1'b0, ok);
      wr(OFS_GEN_CTL, 8'h90);
      settle(2);
      chk("dma_bitio", {7'h00, dma_req}, 8'h00);
      chk("svc_other", {7'h00, svc_req}, 8'h01);
      wr(OFS_GEN_CTL, 8'h10);
      // upper nibble is an output: reads return the output latch there
      rd(OFS_DATA_A, v);
      chk("first_byte", v, 8'h3A);
      settle(2);
      chk("aux_freed", {7'h00, a_aux}, 8'h00);
      rd(OFS_DATA_A, v);
      chk("second_byte", v, 8'h33);
      rd(OFS_STATUS, v);
      chk("dropped_strobe", v, 8'h00);
      periph.send(8'h77, 1'b1, ok);
      rd(OFS_STATUS, v);
      chk("present_again", v, 8'h01);
      wr(OFS_GEN_CTL, 8'h00);
      rd(OFS_STATUS, v);
      chk("disable_empties", v, 8'h00);
      // pulsed ready: count asserted cycles after enabling
      wr(OFS_CTL_A, 8'h3A);
      wr(OFS_GEN_CTL, 8'h10);
      lows = 0;
      repeat (20) begin
         settle(1);
         if (a_aux === 1'b0) begin
            lows++;
         end
      end
      chk("pulse_len", lows[7:0], {5'h00, PULSE_CYC});
      // aux pin as status input
      wr(OFS_CTL_A, 8'h04);
      @(posedge clk_sys_i);
      aux_in <= 1'b0;
      settle(3);
      rd(OFS_STATUS, v);
      chk("aux_flag_set", v, 8'h02);
      chk("aux_irq_on", {7'h00, svc_req}, 8'h01);
      wr(OFS_CTL_A, 8'h00);
      settle(2);
      chk("aux_irq_off", {7'h00, svc_req}, 8'h00);
      wr(OFS_STATUS, 8'h02);
      rd(OFS_STATUS, v);
      chk("aux_flag_clr", v, 8'h00);
      aux_in <= 1'b1;
      // reset in mid-run returns the registers to zero
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle(1);
      chk("oe_a_reset", a_oe, 8'h00);
      rd(OFS_GEN_CTL, v);
      chk("gen_reset", v, REG_RST);
      rd(OFS_CTL_A, v);
      chk("ctl_a_reset", v, REG_RST);
      summarize();
   end
endmodule : uhs_port_top_tb
`default_nettype wire
